// ### rtl/esm_map.svh
// Register offsets, field positions, reset values and timing for the error-signal monitor.
`ifndef ESM_MAP_SVH
`define ESM_MAP_SVH
`define ESM_CTRL_OFS 8'h00
`define ESM_CFG_OFS 8'h04
`define ESM_THR_L_OFS 8'h08
`define ESM_THR_H_OFS 8'h0C
`define ESM_STAT_OFS 8'h10
`define ESM_CTRL_DIS_BIT 0
`define ESM_CTRL_LEAVE_BIT 1
`define ESM_CTRL_BIST_BIT 2
`define ESM_CFG_MODE_BIT 0
`define ESM_STAT_FAIL_BIT 0
`define ESM_STAT_WDF_BIT 1
`define ESM_STAT_BIST_BIT 2
`define ESM_STAT_BFAIL_BIT 3
`define ESM_THR_RST 8'h00
`define ESM_CLK_NS 100
`define ESM_TICK_LP_US 5
`define ESM_TICK_PW_US 15
`define ESM_DEGL_US 15
`define ESM_BIST_CYC 16
`endif

// ### rtl/esm_pkg.sv
// Types shared by the error-signal monitor.
`default_nettype none
package esm_pkg;
  typedef enum logic [1:0] {ESM_DIAG, ESM_ACTIVE, ESM_SAFE} esm_state_e;
  typedef logic [7:0] esm_cnt_t;
endpackage
`default_nettype wire

// ### rtl/esm_monitor.sv
// Error-signal monitor with device state, self-test and AHB-Lite registers.
`include "esm_map.svh"
`default_nettype none
// Behaviour
// - Monitor idle until disable bit cleared.
// - One config bit selects the mode.
// - Low threshold both modes, high for pwm.
// - Every pin error sets the fail flag; self-test failure does not.
// - Operating error enters safe, counts transitions.
// - Diagnostic injection shows only in flag.
// - Input synchronised first, then deglitched.
// - Self-test at reset or on request outside safe state.
// - Low-pulse error after programmed low time.
// - Falling edge clears low counter, then resumes.
// - Low counter ticks 5us, equality fails.
// - Flag next cycle, safe one later.
// - Pwm error when either phase too long.
// - Both pwm limits in 15us steps.
// - Pwm fall or low enable clears counter.
// - Pwm low counter ticks 15us.
// - Pwm rise or high enable clears high.
// - Diagnostic errors enter safe only if flag still set at leave.
module esm_monitor import esm_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Pin and system
  input wire logic mcu_fault_input_pin,
  input wire logic watchdog_failure_flag,
  output logic safe_state,
  output logic [3:0] device_fault_count
);
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int LPT = (`ESM_TICK_LP_US * 1000 + `ESM_CLK_NS - 1) / `ESM_CLK_NS;
  localparam int PWT = (`ESM_TICK_PW_US * 1000 + `ESM_CLK_NS - 1) / `ESM_CLK_NS;
  localparam int DGT = (`ESM_DEGL_US * 1000 + `ESM_CLK_NS - 1) / `ESM_CLK_NS;

  function automatic logic thr_hit(input esm_cnt_t cnt, input esm_cnt_t thr);
    thr_hit = (cnt == thr);
  endfunction

  logic dis_q, mode_q, fail_q, det_q, bist_q, bfail_q, leave_q;
  logic [4:0] bcnt_q;
  esm_cnt_t thr_l_q, thr_h_q, lo_cnt_q, hi_cnt_q, lo_pre_q, hi_pre_q;
  logic [7:0] dg_cnt_q;
  logic s1_q, s2_q, filt_q, filt_p_q, en_p_q;
  logic [3:0] cnt_q;
  esm_state_e state_q;
  logic ap_q, aw_q;
  logic [7:0] aa_q;
  logic [31:0] rd_q;
  logic en, fall, rise, en_rise, lo_clr, hi_clr, detect, wr, wfail, wleave, wbist;
  esm_cnt_t per;

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rd_q;
  assign wr = ap_q && aw_q;
  assign wfail = wr && aa_q == `ESM_STAT_OFS && hwdata[`ESM_STAT_FAIL_BIT];
  assign wleave = wr && aa_q == `ESM_CTRL_OFS && hwdata[`ESM_CTRL_LEAVE_BIT];
  assign wbist = wr && aa_q == `ESM_CTRL_OFS && hwdata[`ESM_CTRL_BIST_BIT];

  always_ff @(posedge clk) begin
    if (!resetn) begin
      ap_q <= 1'b0;
      aw_q <= 1'b0;
      aa_q <= 8'h00;
      rd_q <= 32'h0000_0000;
    end else begin
      ap_q <= hsel && htrans[1] && hready && hsize == 3'h2 && haddr[31:8] == 24'h00_0000;
      aw_q <= hwrite;
      aa_q <= haddr[7:0];
      rd_q <= 32'h0000_0000;
      if (hsel && htrans[1] && hready && !hwrite && haddr[31:8] == 24'h00_0000) begin
        unique case (haddr[7:0])
          `ESM_CTRL_OFS: rd_q <= {31'h0000_0000, dis_q};
          `ESM_CFG_OFS: rd_q <= {31'h0000_0000, mode_q};
          `ESM_THR_L_OFS: rd_q <= {24'h00_0000, thr_l_q};
          `ESM_THR_H_OFS: rd_q <= {24'h00_0000, thr_h_q};
          `ESM_STAT_OFS: rd_q <= {16'h0000, 4'h0, 2'b00, state_q, cnt_q, bfail_q, bist_q,
                                  watchdog_failure_flag, fail_q};
          default: rd_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      dis_q <= 1'b1;
      mode_q <= 1'b0;
      thr_l_q <= `ESM_THR_RST;
      thr_h_q <= `ESM_THR_RST;
    end else if (wr) begin
      if (aa_q == `ESM_CTRL_OFS) begin
        dis_q <= hwdata[`ESM_CTRL_DIS_BIT];
      end
      if (aa_q == `ESM_CFG_OFS) begin
        mode_q <= hwdata[`ESM_CFG_MODE_BIT];
      end
      if (aa_q == `ESM_THR_L_OFS) begin
        thr_l_q <= hwdata[7:0];
      end
      if (aa_q == `ESM_THR_H_OFS) begin
        thr_h_q <= hwdata[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Synchroniser and deglitch filter
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      filt_q <= 1'b1;
      filt_p_q <= 1'b1;
      dg_cnt_q <= 8'h00;
    end else begin
      s1_q <= mcu_fault_input_pin;
      s2_q <= s1_q;
      filt_p_q <= filt_q;
      if (s2_q == filt_q) begin
        dg_cnt_q <= 8'h00;
      end else if (dg_cnt_q == 8'(DGT - 1)) begin
        filt_q <= s2_q;
        dg_cnt_q <= 8'h00;
      end else begin
        dg_cnt_q <= dg_cnt_q + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Duration counters
  // ----------------------------------------------------------------
  // The monitor is frozen while the self-test owns the compare logic.
  assign en = !dis_q && !bist_q;
  assign en_rise = en && !en_p_q;
  assign fall = filt_p_q && !filt_q;
  assign rise = !filt_p_q && filt_q;
  assign per = mode_q ? 8'(PWT) : 8'(LPT);
  assign lo_clr = en && (fall || (en_rise && !filt_q));
  assign hi_clr = en && mode_q && (rise || (en_rise && filt_q));

  always_ff @(posedge clk) begin
    if (!resetn) begin
      en_p_q <= 1'b0;
      lo_cnt_q <= 8'h00;
      lo_pre_q <= 8'h00;
    end else begin
      en_p_q <= en;
      if (lo_clr) begin
        lo_cnt_q <= 8'h00;
        lo_pre_q <= 8'h00;
      end else if (en && !filt_q) begin
        if (lo_pre_q == per - 8'h01) begin
          lo_pre_q <= 8'h00;
          if (lo_cnt_q != 8'hFF) begin
            lo_cnt_q <= lo_cnt_q + 8'h01;
          end
        end else begin
          lo_pre_q <= lo_pre_q + 8'h01;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      hi_cnt_q <= 8'h00;
      hi_pre_q <= 8'h00;
    end else if (hi_clr) begin
      hi_cnt_q <= 8'h00;
      hi_pre_q <= 8'h00;
    end else if (en && mode_q && filt_q) begin
      if (hi_pre_q == per - 8'h01) begin
        hi_pre_q <= 8'h00;
        if (hi_cnt_q != 8'hFF) begin
          hi_cnt_q <= hi_cnt_q + 8'h01;
        end
      end else begin
        hi_pre_q <= hi_pre_q + 8'h01;
      end
    end
  end

  // Rising edges only halt the low counter in either mode, so a stale count waits.
  assign detect = en && !lo_clr && !hi_clr &&
                  ((!filt_q && thr_hit(lo_cnt_q, thr_l_q)) ||
                   (mode_q && filt_q && thr_hit(hi_cnt_q, thr_h_q)));

  // ----------------------------------------------------------------
  // Fail flag and device state
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      fail_q <= 1'b0;
      det_q <= 1'b0;
    end else begin
      det_q <= detect;
      if (detect) begin
        fail_q <= 1'b1;
      end else if (wfail) begin
        fail_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_q <= ESM_DIAG;
      cnt_q <= 4'h0;
      leave_q <= 1'b0;
    end else begin
      leave_q <= wleave;
      unique case (state_q)
        ESM_DIAG: begin
          if (leave_q) begin
            if (fail_q || watchdog_failure_flag) begin
              state_q <= ESM_SAFE;
              cnt_q <= cnt_q + 4'h1;
            end else begin
              state_q <= ESM_ACTIVE;
            end
          end
        end
        ESM_ACTIVE: begin
          if (det_q || bfail_q) begin
            state_q <= ESM_SAFE;
            cnt_q <= cnt_q + 4'h1;
          end
        end
        ESM_SAFE: state_q <= ESM_SAFE;
      endcase
    end
  end

  assign safe_state = state_q == ESM_SAFE;
  assign device_fault_count = cnt_q;

  // ----------------------------------------------------------------
  // Logic self-test
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      bist_q <= 1'b1;
      bcnt_q <= 5'h00;
      bfail_q <= 1'b0;
    end else if (bist_q) begin
      bcnt_q <= bcnt_q + 5'h01;
      if (bcnt_q == 5'(`ESM_BIST_CYC - 1)) begin
        bist_q <= 1'b0;
        bfail_q <= !thr_hit(8'hA5, 8'hA5) || thr_hit(8'h5A, 8'hA5);
      end
    end else if (wbist && state_q != ESM_SAFE) begin
      bist_q <= 1'b1;
      bcnt_q <= 5'h00;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_idle_quiet: assert property (@(posedge clk) disable iff (!resetn)
    $rose(fail_q) |-> !$past(dis_q)) else $error("flag set while disabled");
  a_flag_set: assert property (@(posedge clk) disable iff (!resetn)
    detect |=> fail_q) else $error("fail flag missed");
  a_safe_follow: assert property (@(posedge clk) disable iff (!resetn)
    state_q == ESM_ACTIVE && detect |=> fail_q ##1 state_q == ESM_SAFE)
    else $error("safe late");
  a_count_step: assert property (@(posedge clk) disable iff (!resetn)
    state_q == ESM_ACTIVE ##1 state_q == ESM_SAFE |-> cnt_q == $past(cnt_q) + 4'h1)
    else $error("count wrong");
  a_diag_stay: assert property (@(posedge clk) disable iff (!resetn)
    state_q == ESM_DIAG && !leave_q |=> state_q != ESM_SAFE)
    else $error("diag went safe");
  a_fall_clear: assert property (@(posedge clk) disable iff (!resetn)
    lo_clr |=> lo_cnt_q == 8'h00 && lo_pre_q == 8'h00) else $error("low clr");
  a_rise_clear: assert property (@(posedge clk) disable iff (!resetn)
    en && mode_q && rise |=> hi_cnt_q == 8'h00) else $error("high clr");
  a_lo_tick: assert property (@(posedge clk) disable iff (!resetn)
    $changed(lo_cnt_q) && lo_cnt_q != 8'h00 |-> $past(lo_pre_q) == $past(per) - 8'h01)
    else $error("low tick");
  a_deglitch: assert property (@(posedge clk) disable iff (!resetn)
    $changed(filt_q) |-> $past(dg_cnt_q) == 8'(DGT - 1)) else $error("deglitch");
  c_active_err: cover property (@(posedge clk) disable iff (!resetn)
    state_q == ESM_ACTIVE && detect);
  c_pwm_high: cover property (@(posedge clk) disable iff (!resetn)
    mode_q && filt_q && detect);
  c_diag_flag: cover property (@(posedge clk) disable iff (!resetn)
    state_q == ESM_DIAG && detect);
endmodule
`default_nettype wire

// ### verif/esm_mcu_model.sv
// Behavioural microcontroller driving the fault signalling pin.
`default_nettype none
module esm_mcu_model (
  // Clock
  input wire logic clk,
  // Pin
  output logic pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle high, since the watchdog is assumed to run question-answer and leaves the pin alone.
  initial pin = 1'b1;
  // An emulated error, or a healthy pulse, is a low phase of n cycles.
  task automatic pulse_low(input int n);
    pin <= 1'b0;
    repeat (n) @(posedge clk);
    pin <= 1'b1;
  endtask
  task automatic toggle(input int half, input int periods);
    repeat (periods) begin
      pin <= 1'b0;
      repeat (half) @(posedge clk);
      pin <= 1'b1;
      repeat (half) @(posedge clk);
    end
  endtask
endmodule
`default_nettype wire

// ### verif/mcu_error_signal_monitor_test.sv
// Self-checking bench for the error-signal monitor.
`include "esm_map.svh"
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_errors++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module mcu_error_signal_monitor_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, resetn = 0, hsel = 0, hwrite = 0, wdf = 0;
  logic [1:0] htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0;
  logic hreadyout, hresp, safe_state, pin;
  logic [31:0] hrdata;
  logic [3:0] cnt;
  int n_errors = 0, check_count = 0;
  esm_monitor i_dut (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .mcu_fault_input_pin(pin),
    .watchdog_failure_flag(wdf), .safe_state(safe_state), .device_fault_count(cnt));
  esm_mcu_model i_mcu (.clk(clk), .pin(pin));
  always #50 clk = ~clk;
  // ----------------------------------------
  // Bus and reporting tasks
  // ----------------------------------------
  task automatic test_done();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Waits for hready seen high at a rising edge; values are taken before that edge.
  task automatic wait_ready(output logic [31:0] rd);
    logic r;
    int n;
    n = 0;
    do begin
      @(negedge clk);
      r = hreadyout;
      rd = hrdata;
      @(posedge clk);
      n++;
    end while (r !== 1'b1 && n < 50);
    if (r !== 1'b1) begin
      n_errors++;
      test_done();
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    wait_ready(rd);
    htrans <= 2'b00;
    hwdata <= d;
    wait_ready(rd);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(a, 1'b1, d, x);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] x;
    bus(a, 1'b0, 32'h0, x);
    `CHK("register", e, x & m)
  endtask
  task automatic reset_dut();
    resetn <= 1'b0;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    repeat (20) @(posedge clk);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    rdc(`ESM_CTRL_OFS, 32'hFFFF_FFFF, 32'h0000_0001);
    @(negedge clk);
    `CHK("hresp", 1'b0, hresp)
    rdc(`ESM_STAT_OFS, 32'h0000_03FF, 32'h0000_0000);
    wr(8'h40, 32'hFFFF_FFFF);
    rdc(8'h40, 32'hFFFF_FFFF, 32'h0000_0000);
    wr(`ESM_CTRL_OFS, 32'h0000_0005);
    rdc(`ESM_STAT_OFS, 32'h0000_0004, 32'h0000_0004);
    repeat (30) @(posedge clk);
    rdc(`ESM_STAT_OFS, 32'h0000_000C, 32'h0000_0000);
  endtask
  task automatic t_low_pulse();
    wr(`ESM_THR_L_OFS, 32'h0000_0005);
    wr(`ESM_CTRL_OFS, 32'h0000_0000);
    i_mcu.pulse_low(400);
    repeat (200) @(posedge clk);
    rdc(`ESM_STAT_OFS, 32'h0000_0301, 32'h0000_0001);
    @(negedge clk);
    `CHK("safe_state", 1'b0, safe_state)
    wr(`ESM_STAT_OFS, 32'h0000_0001);
    rdc(`ESM_STAT_OFS, 32'h0000_0001, 32'h0000_0000);
    // Two pulses of three ticks each only fail if the count survives a falling edge.
    repeat (2) begin
      i_mcu.pulse_low(200);
      repeat (300) @(posedge clk);
    end
    rdc(`ESM_STAT_OFS, 32'h0000_0001, 32'h0000_0000);
  endtask
  task automatic t_pwm();
    wr(`ESM_CTRL_OFS, 32'h0000_0001);
    wr(`ESM_CFG_OFS, 32'h0000_0001);
    wr(`ESM_THR_L_OFS, 32'h0000_0004);
    wr(`ESM_THR_H_OFS, 32'h0000_0004);
    wr(`ESM_CTRL_OFS, 32'h0000_0000);
    i_mcu.toggle(400, 4);
    rdc(`ESM_STAT_OFS, 32'h0000_0001, 32'h0000_0000);
    repeat (800) @(posedge clk);
    rdc(`ESM_STAT_OFS, 32'h0000_0001, 32'h0000_0001);
    wr(`ESM_STAT_OFS, 32'h0000_0001);
    i_mcu.pulse_low(1000);
    rdc(`ESM_STAT_OFS, 32'h0000_0001, 32'h0000_0001);
  endtask
  task automatic t_active();
    int n;
    wr(`ESM_STAT_OFS, 32'h0000_0001);
    wr(`ESM_CTRL_OFS, 32'h0000_0002);
    rdc(`ESM_STAT_OFS, 32'h0000_0301, 32'h0000_0100);
    // The high phase left running after the last pulse is the operating error.
    for (n = 0; n < 1000 && safe_state !== 1'b1; n++) @(negedge clk);
    `CHK("safe_state", 1'b1, safe_state)
    rdc(`ESM_STAT_OFS, 32'h0000_03F1, 32'h0000_0211);
  endtask
  task automatic t_watchdog_exit();
    reset_dut();
    @(negedge clk);
    `CHK("count", 4'h0, cnt)
    @(posedge clk);
    wdf <= 1'b1;
    wr(`ESM_CTRL_OFS, 32'h0000_0002);
    rdc(`ESM_STAT_OFS, 32'h0000_03F2, 32'h0000_0212);
    wdf <= 1'b0;
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    test_done();
  end
  initial begin
    reset_dut();
    t_reset();
    t_low_pulse();
    t_pwm();
    t_active();
    t_watchdog_exit();
    test_done();
  end
endmodule
`default_nettype wire
